// ---- include/ppl_pkg.sv ----
// Package for the parallel port lines block
`default_nettype none

package ppl_pkg;
    // Register map: one aligned word per register, port index in [7:4]
    localparam logic [7:0] ppl_port_stride = 8'h10;
    localparam logic [3:0] ppl_off_data = 4'h0;
    localparam logic [3:0] ppl_off_dir = 4'h4;
    localparam logic [3:0] ppl_off_odrain = 4'h8;
    localparam logic [3:0] ppl_off_altena = 4'hc;
    localparam logic [7:0] ppl_off_thresh = 8'ha0;
    localparam logic [7:0] ppl_off_ext_thresh = 8'ha4;
    localparam logic [7:0] ppl_off_bus_mode = 8'ha8;
    localparam int ppl_num_ports = 9;
    // Implemented line masks per port 0..8
    localparam logic [15:0] ppl_mask_p0 = 16'hffff;
    localparam logic [15:0] ppl_mask_p1 = 16'hffff;
    localparam logic [15:0] ppl_mask_p2 = 16'hffff;
    localparam logic [15:0] ppl_mask_p3 = 16'hbfff;
    localparam logic [15:0] ppl_mask_p4 = 16'h00ff;
    localparam logic [15:0] ppl_mask_p5 = 16'hffff;
    localparam logic [15:0] ppl_mask_p6 = 16'h00ff;
    localparam logic [15:0] ppl_mask_p7 = 16'h00ff;
    localparam logic [15:0] ppl_mask_p8 = 16'h00ff;
    // Ports offering open-drain drivers: 2,3,4,6,7,8
    localparam logic [8:0] ppl_odrain_ports = 9'h1dc;
    // Port 5 is input only
    localparam logic [8:0] ppl_input_only = 9'h020;
    // Ports whose alternate output is not gated by the latch (PWM lines)
    localparam logic [8:0] ppl_pwm_ports = 9'h000;
    // Reset values
    localparam logic [15:0] ppl_rst_data = 16'h0000;
    localparam logic [15:0] ppl_rst_dir = 16'h0000;
    localparam logic [15:0] ppl_rst_zero = 16'h0000;
    // Threshold select widths
    localparam int ppl_thresh_bits = 7;
    localparam int ppl_ext_thresh_bits = 6;
    // AXI responses
    localparam logic [1:0] ppl_resp_okay = 2'b00;
    localparam logic [1:0] ppl_resp_slverr = 2'b10;
endpackage : ppl_pkg

`default_nettype wire

// ---- core/ppl_port_lines.sv ----
// Parallel I/O port lines with AXI4-Lite register access
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`default_nettype none

module ppl_port_lines
(
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins, port p at bits [16p+15:16p]
    input wire logic [143:0] pin_in,
    output logic [143:0] pin_out,
    output logic [143:0] pin_oe_n,
    // Alternate functions
    input wire logic [143:0] alt_out_data,
    input wire logic [143:0] alt_out_dir,
    output logic [143:0] alt_in_data,
    // Hardware bus direction for ports 0 and 1
    input wire logic [31:0] bus_dir,
    // Threshold selects to pad cells
    output logic [6:0] input_threshold_select,
    output logic [5:0] ext_input_threshold_select
);
    localparam int np = ppl_pkg::ppl_num_ports;
    localparam logic [15:0] masks [np] = '{ppl_pkg::ppl_mask_p0,
        ppl_pkg::ppl_mask_p1, ppl_pkg::ppl_mask_p2, ppl_pkg::ppl_mask_p3,
        ppl_pkg::ppl_mask_p4, ppl_pkg::ppl_mask_p5, ppl_pkg::ppl_mask_p6,
        ppl_pkg::ppl_mask_p7, ppl_pkg::ppl_mask_p8};

    // ============================================================
    // Register state
    logic [15:0] data_q [np];
    logic [15:0] pin_direction_bit_q [np];
    logic [15:0] open_drain_select_reg_q [np];
    logic [15:0] alt_en_q [np];
    logic [15:0] sync1_q [np];
    logic [15:0] sample_q [np];
    logic [6:0] thr_q;
    logic [5:0] xthr_q;
    logic [1:0] bus_mode_q;
    logic [15:0] eff_dir [np];
    logic [15:0] rd_val [np];

    // ============================================================
    // Write channel
    logic aw_got_q, w_got_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic [3:0] wr_port;
    logic [15:0] wr_half;
    logic [15:0] wr_bmask;

    assign s_axi_awready = clk_en && !aw_got_q && !s_axi_bvalid;
    assign s_axi_wready = clk_en && !w_got_q && !s_axi_bvalid;
    assign wr_fire = clk_en && aw_got_q && w_got_q && !s_axi_bvalid;
    assign wr_port = aw_addr_q[7:4];
    assign wr_half = w_data_q[15:0];
    assign wr_bmask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ppl_pkg::ppl_resp_okay;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok(aw_addr_q) ? ppl_pkg::ppl_resp_okay
                    : ppl_pkg::ppl_resp_slverr;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Address decode shared by read and write
    function automatic logic wr_ok(input logic [7:0] a);
        logic ok;
        ok = 1'b0;
        if (a[1:0] != 2'b00)
            ok = 1'b0;
        else if (a[7:4] < 4'(np))
            ok = 1'b1;
        else if (a == ppl_pkg::ppl_off_thresh
            || a == ppl_pkg::ppl_off_ext_thresh
            || a == ppl_pkg::ppl_off_bus_mode)
            ok = 1'b1;
        return ok;
    endfunction : wr_ok

    // ============================================================
    // Per-port logic
    genvar p;
    generate
        for (p = 0; p < np; p++)
        begin : g_port
            logic sel;
            logic [15:0] alt_gated;
            logic [15:0] drive_val;
            logic [15:0] drv_oe;
            assign sel = wr_fire && wr_port == 4'(p)
                && aw_addr_q[7:4] < 4'(np);

            // Pin synchroniser and input latch
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    sync1_q[p] <= ppl_pkg::ppl_rst_zero;
                    sample_q[p] <= ppl_pkg::ppl_rst_zero;
                end
                else if (clk_en)
                begin
                    sync1_q[p] <= pin_in[16*p +: 16];
                    sample_q[p] <= sync1_q[p] & masks[p];
                end
            end

            // Control registers; data write lands in latch only
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    data_q[p] <= ppl_pkg::ppl_rst_data;
                    pin_direction_bit_q[p] <= ppl_pkg::ppl_rst_dir;
                    open_drain_select_reg_q[p] <= ppl_pkg::ppl_rst_zero;
                    alt_en_q[p] <= ppl_pkg::ppl_rst_zero;
                end
                else if (clk_en && sel)
                begin
                    case (aw_addr_q[3:0])
                        ppl_pkg::ppl_off_data:
                            data_q[p] <= ((data_q[p] & ~wr_bmask)
                                | (wr_half & wr_bmask)) & masks[p];
                        ppl_pkg::ppl_off_dir:
                            if (!ppl_pkg::ppl_input_only[p])
                                pin_direction_bit_q[p] <= ((pin_direction_bit_q[p]
                                    & ~wr_bmask) | (wr_half & wr_bmask))
                                    & masks[p];
                        ppl_pkg::ppl_off_odrain:
                            if (ppl_pkg::ppl_odrain_ports[p])
                                open_drain_select_reg_q[p] <=
                                    ((open_drain_select_reg_q[p] & ~wr_bmask)
                                    | (wr_half & wr_bmask)) & masks[p];
                        ppl_pkg::ppl_off_altena:
                            if (!ppl_pkg::ppl_input_only[p])
                                alt_en_q[p] <= ((alt_en_q[p] & ~wr_bmask)
                                    | (wr_half & wr_bmask)) & masks[p];
                        default:
                            ;
                    endcase
                end
            end

            // Effective direction: bus mode overrides on ports 0 and 1
            if (p < 2)
            begin : g_bus
                assign eff_dir[p] = bus_mode_q[p]
                    ? bus_dir[16*p +: 16] & masks[p]
                    : pin_direction_bit_q[p];
            end
            else
            begin : g_nobus
                assign eff_dir[p] = pin_direction_bit_q[p];
            end

            // Read source per pin
            assign rd_val[p] = (eff_dir[p] & data_q[p])
                | (~eff_dir[p] & sample_q[p]);

            // Output path; threshold plays no part here
            assign alt_gated = ppl_pkg::ppl_pwm_ports[p]
                ? alt_out_data[16*p +: 16]
                : alt_out_data[16*p +: 16] & data_q[p];
            assign drive_val = ((alt_en_q[p] & alt_out_dir[16*p +: 16]
                & alt_gated) | (~(alt_en_q[p] & alt_out_dir[16*p +: 16])
                & data_q[p])) & masks[p];
            assign drv_oe = eff_dir[p] & ~(open_drain_select_reg_q[p]
                & drive_val);
            assign pin_out[16*p +: 16] = drive_val
                & ~open_drain_select_reg_q[p];
            assign pin_oe_n[16*p +: 16] = ~drv_oe;
            assign alt_in_data[16*p +: 16] = rd_val[p];
        end
    endgenerate

    // ============================================================
    // Global registers: thresholds and bus mode
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            thr_q <= 7'h00;
            xthr_q <= 6'h00;
            bus_mode_q <= 2'b00;
        end
        else if (clk_en && wr_fire && w_strb_q[0])
        begin
            case (aw_addr_q)
                ppl_pkg::ppl_off_thresh:
                    thr_q <= w_data_q[6:0];
                ppl_pkg::ppl_off_ext_thresh:
                    xthr_q <= w_data_q[5:0];
                ppl_pkg::ppl_off_bus_mode:
                    bus_mode_q <= w_data_q[1:0];
                default:
                    ;
            endcase
        end
    end
    assign input_threshold_select = thr_q;
    assign ext_input_threshold_select = xthr_q;

    // ============================================================
    // Read channel
    logic [31:0] rd_word;
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (s_axi_araddr[7:4] < 4'(np))
        begin
            case (s_axi_araddr[3:0])
                ppl_pkg::ppl_off_data:
                    rd_word = {16'h0000, rd_val[s_axi_araddr[7:4]]};
                ppl_pkg::ppl_off_dir:
                    rd_word = {16'h0000,
                        pin_direction_bit_q[s_axi_araddr[7:4]]};
                ppl_pkg::ppl_off_odrain:
                    rd_word = {16'h0000,
                        open_drain_select_reg_q[s_axi_araddr[7:4]]};
                ppl_pkg::ppl_off_altena:
                    rd_word = {16'h0000, alt_en_q[s_axi_araddr[7:4]]};
                default:
                    rd_word = 32'h0000_0000;
            endcase
        end
        else if (s_axi_araddr == ppl_pkg::ppl_off_thresh)
            rd_word = {25'h0, thr_q};
        else if (s_axi_araddr == ppl_pkg::ppl_off_ext_thresh)
            rd_word = {26'h0, xthr_q};
        else if (s_axi_araddr == ppl_pkg::ppl_off_bus_mode)
            rd_word = {30'h0, bus_mode_q};
    end

    assign s_axi_arready = clk_en && !s_axi_rvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ppl_pkg::ppl_resp_okay;
        end
        else if (clk_en)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= wr_ok(s_axi_araddr) ? ppl_pkg::ppl_resp_okay
                    : ppl_pkg::ppl_resp_slverr;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule : ppl_port_lines

`default_nettype wire

// ---- tb/ppl_props.sv ----
// Checker for the parallel port lines block
`default_nettype none

// ========
// Checker
module ppl_props
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Pins and alternates
    input wire logic [143:0] pin_in,
    input wire logic [143:0] pin_out,
    input wire logic [143:0] pin_oe_n,
    input wire logic [143:0] alt_out_dir,
    input wire logic [143:0] alt_in_data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_RST_OE: assert property (disable iff (1'b0)
        !aresetn |=> pin_oe_n == 144'hffff_ffff_ffff_ffff_ffff_ffff_ffff_ffff_ffff)
        else $error("driver on after reset");
    AST_P5_IN: assert property (pin_oe_n[95:80] == 16'hffff)
        else $error("input only port driven");
    AST_ABSENT: assert property (&{pin_oe_n[62], pin_oe_n[79:72],
        pin_oe_n[111:104], pin_oe_n[127:120], pin_oe_n[143:136]})
        else $error("absent line driven");
    AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_WR_REFUSE: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    AST_RD_RESP: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready)
        else $error("read answer late");
    AST_RD_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    AST_ALT_IN: assert property (
        ((alt_in_data[143:32] ^ pin_out[143:32]) & ~pin_oe_n[143:32]
        & ~alt_out_dir[143:32]) == 112'h0)
        else $error("alternate input differs from latch");
    AST_SAMPLE: assert property (
        (pin_oe_n[47:32] == 16'hffff && $stable(pin_in[47:32])) [*4]
        |-> alt_in_data[47:32] == pin_in[47:32])
        else $error("pin level not sampled");
endmodule : ppl_props

bind ppl_port_lines ppl_props u_props (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .pin_in, .pin_out,
    .pin_oe_n, .alt_out_dir, .alt_in_data);

`default_nettype wire

// ---- tb/ppl_pin_env.sv ----
// External devices and pull-ups at the port pins
`default_nettype none

// ========
// Pin environment
module ppl_pin_env
(
    // Device side
    input wire logic [143:0] pin_out,
    input wire logic [143:0] pin_oe_n,
    // Far side drivers
    input wire logic [143:0] ext_val,
    input wire logic [143:0] ext_en,
    // Wire levels
    output logic [143:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released and undriven lines float up
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
        | (pin_oe_n & ~ext_en);
endmodule : ppl_pin_env

`default_nettype wire

// ---- tb/tb_top.sv ----
// Testbench for the parallel port lines block
`default_nettype none

// ========
// Bench
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [3:0] p;
        logic [15:0] dir;
        logic [15:0] dat;
        logic [15:0] ext;
        logic [15:0] rd;
        logic [15:0] oe;
    } ppl_row_t;
    ppl_row_t rows [5] = '{
        '{4'h2, 16'h00ff, 16'ha5a5, 16'h3c3c, 16'h3ca5, 16'hff00},
        '{4'h3, 16'hffff, 16'hffff, 16'h0000, 16'hbfff, 16'h4000},
        '{4'h4, 16'hffff, 16'h1234, 16'hffff, 16'h0034, 16'hff00},
        '{4'h5, 16'hffff, 16'h1234, 16'h5a5a, 16'h5a5a, 16'hffff},
        '{4'h0, 16'hf0f0, 16'h0ff0, 16'h1111, 16'h01f1, 16'h0f0f}};
    logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, bus_dir = 32'h0, s_axi_rdata, q;
    logic [143:0] alt_out_data = 144'h0, alt_out_dir = 144'h0;
    logic [143:0] ext_val = 144'h0, ext_en = 144'h0;
    logic [143:0] pin_in, pin_out, pin_oe_n, alt_in_data;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [6:0] input_threshold_select;
    logic [5:0] ext_input_threshold_select;
    int bad_count = 0, total_checks = 0, b;

    ppl_port_lines dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in,
        .pin_out, .pin_oe_n, .alt_out_data, .alt_out_dir, .alt_in_data,
        .bus_dir, .input_threshold_select, .ext_input_threshold_select);
    ppl_pin_env u_env (.pin_out, .pin_oe_n, .ext_val, .ext_en, .pin_in);

    always #2.5 aclk = ~aclk;

    // ========
    // Tasks
    task automatic close_out;
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    task automatic cmp(input string nm, input logic [31:0] e, s);
        total_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : cmp

    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        logic ca, cw, cr, dn;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        dn = 1'b0;
        for (int n = 0; n < 40 && !dn; n++)
        begin
            @(negedge aclk);
            ca = s_axi_awvalid && s_axi_awready;
            cw = s_axi_wvalid && s_axi_wready;
            cr = s_axi_arvalid && s_axi_arready;
            dn = w ? s_axi_bvalid : s_axi_rvalid;
            q = s_axi_rdata;
            r = w ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (ca) s_axi_awvalid <= 1'b0;
            if (cw) s_axi_wvalid <= 1'b0;
            if (cr) s_axi_arvalid <= 1'b0;
            if (dn) s_axi_bready <= 1'b0;
            if (dn) s_axi_rready <= 1'b0;
        end
        if (!dn)
        begin
            bad_count++;
            $display("Error bus answer expected 1 seen 0");
            close_out();
        end
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp("read data", e, q);
    endtask : rd_chk

    // ========
    // Sequence
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cmp("oe_n", 32'hffffffff, pin_oe_n[31:0]);
        rd_chk(8'h24, 32'h0);
        foreach (rows[i])
        begin
            b = 16 * rows[i].p;
            ext_en[b +: 16] <= 16'hffff;
            ext_val[b +: 16] <= rows[i].ext;
            bus(1'b1, {rows[i].p, ppl_pkg::ppl_off_dir}, 32'(rows[i].dir));
            bus(1'b1, {rows[i].p, ppl_pkg::ppl_off_data}, 32'(rows[i].dat));
            repeat (3) @(posedge aclk);
            rd_chk({rows[i].p, ppl_pkg::ppl_off_data}, 32'(rows[i].rd));
            cmp("oe_n", 32'(rows[i].oe), 32'(pin_oe_n[b +: 16]));
            cmp("pin", 32'(rows[i].dat & ~rows[i].oe),
                32'(pin_out[b +: 16] & ~rows[i].oe));
        end
        // Read-modify-write on a mixed port
        ext_en[96 +: 16] <= 16'hffff;
        ext_val[96 +: 16] <= 16'h00aa;
        bus(1'b1, 8'h64, 32'h00f0);
        bus(1'b1, 8'h60, 32'h000f);
        repeat (3) @(posedge aclk);
        bus(1'b0, 8'h60, 32'h0);
        cmp("rmw source", 32'h000a, q);
        bus(1'b1, 8'h60, q | 32'h00c0);
        bus(1'b1, 8'h64, 32'h00ff);
        rd_chk(8'h60, 32'h00ca);
        // Open drain
        bus(1'b1, 8'h74, 32'h00ff);
        bus(1'b1, 8'h78, 32'h00ff);
        bus(1'b1, 8'h70, 32'h00f0);
        @(posedge aclk);
        cmp("od oe_n", 32'hfff0, 32'(pin_oe_n[112 +: 16]));
        cmp("od pin", 32'h0, 32'(pin_out[112 +: 4]));
        bus(1'b1, 8'h18, 32'hffff);
        rd_chk(8'h18, 32'h0);
        rd_chk(8'h78, 32'h00ff);
        // Alternate output and input
        alt_out_dir[128 +: 16] <= 16'hffff;
        alt_out_data[128 +: 16] <= 16'h0055;
        bus(1'b1, 8'h8c, 32'h00ff);
        bus(1'b1, 8'h84, 32'h000f);
        bus(1'b1, 8'h80, 32'h00ff);
        @(posedge aclk);
        cmp("alt pin", 32'h5, 32'(pin_out[128 +: 4]));
        cmp("alt oe_n", 32'hfff0, 32'(pin_oe_n[128 +: 16]));
        bus(1'b1, 8'h80, 32'h0003);
        @(posedge aclk);
        cmp("alt and", 32'h1, 32'(pin_out[128 +: 4]));
        cmp("alt in", 32'h3, 32'(alt_in_data[128 +: 4]));
        // Hardware direction, thresholds, unmapped
        bus_dir[15:0] <= 16'h00ff;
        bus(1'b1, 8'ha8, 32'h1);
        @(posedge aclk);
        cmp("bus oe_n", 32'hff00, 32'(pin_oe_n[15:0]));
        rd_chk(8'h04, 32'hf0f0);
        bus(1'b1, 8'ha0, 32'h55);
        bus(1'b1, 8'ha4, 32'h2a);
        @(posedge aclk);
        cmp("thr", 32'h55, 32'(input_threshold_select));
        cmp("xthr", 32'h2a, 32'(ext_input_threshold_select));
        cmp("thr oe_n", 32'hff00, 32'(pin_oe_n[32 +: 16]));
        bus(1'b0, 8'hfc, 32'h0);
        cmp("rresp", 32'(ppl_pkg::ppl_resp_slverr), 32'(r));
        cmp("rdata", 32'h0, q);
        bus(1'b1, 8'hfc, 32'h0);
        cmp("bresp", 32'(ppl_pkg::ppl_resp_slverr), 32'(r));
        // Freeze, byte strobe, reset in mid-run
        clk_en <= 1'b0;
        ext_val[40 +: 8] <= 8'hc3;
        repeat (4) @(posedge aclk);
        cmp("frozen", 32'h3c, 32'(alt_in_data[40 +: 8]));
        clk_en <= 1'b1;
        repeat (3) @(posedge aclk);
        cmp("sample", 32'hc3, 32'(alt_in_data[40 +: 8]));
        s_axi_wstrb <= 4'h1;
        bus(1'b1, 8'h24, 32'hff00);
        cmp("bresp", 32'(ppl_pkg::ppl_resp_okay), 32'(r));
        s_axi_wstrb <= 4'hf;
        rd_chk(8'h24, 32'h0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cmp("rst oe_n", 32'hffff, 32'(pin_oe_n[15:0]));
        rd_chk(8'h04, 32'h0);
        rd_chk(8'ha8, 32'h0);
        close_out();
    end
endmodule : tb_top

`default_nettype wire
